/* wwdt_pkg.sv */
// Purpose: constants and carrier types for the windowed watchdog
// Assumes: oscillator clock is ref_clk, 20 MHz
// Notes:   one package shared by the design, checker and testbench files
package wwdt_pkg;

  localparam logic [7:0] CTRL_ADDR   = 8'h2F;
  localparam logic [7:0] WINDOW_ADDR = 8'h30;

  localparam int         CTRL_ACT_BIT  = 7;
  localparam int         CNT_TOP_BIT   = 6;
  localparam logic [6:0] CTRL_RST_CNT  = 7'h7F;
  localparam logic       CTRL_RST_ACT  = 1'b0;
  localparam logic [6:0] WINDOW_RST    = 7'h7F;
  localparam logic [6:0] CNT_FLOOR     = 7'h3F;
  localparam logic [6:0] CNT_EDGE      = 7'h40;

  localparam int         UNIT_CYCLES   = 64;
  localparam logic [8:0] STEP_UNITS    = 9'h100;
  localparam logic [8:0] SHORT_BASE    = 9'h0C0;

  localparam logic [5:0] TB_MSB [4] = '{6'h04, 6'h08, 6'h14, 6'h31};
  localparam logic [5:0] TB_LSB [4] = '{6'h3B, 6'h35, 6'h23, 6'h36};

  localparam int         CLK_NS          = 50;
  localparam int         RST_PULSE_NS    = 30000;
  localparam int         RST_PULSE_CYC   = RST_PULSE_NS / CLK_NS;
  localparam logic [12:0] STARTUP_SHORT  = 13'h0100;
  localparam logic [12:0] STARTUP_LONG   = 13'h1000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wwdt_bus_req_s;

  typedef struct packed {
    logic halt_req;
    logic wake_irq;
    logic rtc_irq_enable;
    logic halt_exit_rst;
  } wwdt_pwr_s;

  typedef enum logic [4:0] {
    ST_RUN      = 5'b0_0001,
    ST_HALT_DEC = 5'b0_0010,
    ST_HALTED   = 5'b0_0100,
    ST_ACT_HALT = 5'b0_1000,
    ST_STARTUP  = 5'b1_0000
  } wwdt_mode_e;

endpackage : wwdt_pkg

/* wwdt_top.sv */
// Purpose: windowed watchdog with free-running 7-bit downcounter
// Assumes: ref_clk is the oscillator clock; option inputs are static
// Notes:   register port answers reads one cycle later, never stalls
`timescale 1ns/10ps
module wwdt_top
  import wwdt_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire wwdt_bus_req_s bus_req,
  output logic [7:0]         rd_data,
  input  wire wwdt_pwr_s     pwr,
  input  wire logic [1:0]    time_base_select,
  input  wire logic          hw_always_on,
  input  wire logic          halt_reset_option,
  input  wire logic          startup_long_sel,
  output logic               mcu_rst_n,
  output logic               wd_active
);

  logic [6:0]  cnt_q;
  logic        act_bit_q;
  logic [6:0]  window_q;
  logic [7:0]  rd_data_q;
  logic [5:0]  unit_q;
  logic [8:0]  step_q;
  logic [8:0]  step_len;
  logic [5:0]  acc_q;
  logic [5:0]  acc_sum;
  logic        short_q;
  logic [1:0]  tb_q;
  logic        unit_tick;
  logic        step_tick;
  logic [9:0]  pulse_q;
  logic        mcu_rst_n_q;
  logic [12:0] delay_q;
  logic        boot_q;
  wwdt_mode_e  mode_q;
  logic        active;
  logic        ctrl_wr;
  logic        win_wr;
  logic        counting;
  logic        fire;
  logic        bad_reload;
  logic        halt_fire;
  logic        expire;
  logic        rst_block;
  logic [5:0]  unit_d;
  logic [8:0]  step_d;
  logic [5:0]  acc_d;
  logic        short_d;
  logic [1:0]  tb_d;
  logic        act_d;
  logic [6:0]  window_d;
  logic [6:0]  cnt_d;
  logic [7:0]  rd_data_d;
  logic [9:0]  pulse_d;
  logic        mcu_rst_n_d;
  wwdt_mode_e  mode_d;
  logic [12:0] delay_d;
  logic [12:0] startup_len;
  logic        sw_fire;
  logic        reload_fire;
  logic        boot_exit;

  assign active    = hw_always_on | act_bit_q;
  assign ctrl_wr   = bus_req.wr && (bus_req.addr == CTRL_ADDR);
  assign win_wr    = bus_req.wr && (bus_req.addr == WINDOW_ADDR);
  // counting ignores slow and wait, which are not even inputs here
  assign counting  = (mode_q == ST_RUN) || (mode_q == ST_HALT_DEC);
  assign rst_block = (mode_q == ST_HALT_DEC) || (mode_q == ST_HALTED);

  // 64-cycle unit divider, then steps of a whole number of units
  assign unit_tick = (unit_q == 6'(UNIT_CYCLES - 1));
  // short steps land on time base rollover
  assign step_len  = short_q ? (SHORT_BASE + {3'b000, TB_LSB[tb_q]})
                             : STEP_UNITS;
  assign step_tick = unit_tick && (step_q == step_len - 9'h001);
  assign acc_sum   = acc_q + 6'h04;

  // free-running: a write never restarts the prescaler
  assign unit_d = unit_q + 6'h01;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_q <= '0;
    end else begin
      unit_q <= unit_d;
    end
  end

  always_comb begin
    step_d = step_q;
    if (step_tick) begin
      step_d = '0;
    end else if (unit_tick) begin
      step_d = step_q + 9'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= '0;
    end else begin
      step_q <= step_d;
    end
  end

  // accumulator yields floor(4*steps/MSB) short steps without a divider
  always_comb begin
    acc_d   = acc_q;
    short_d = short_q;
    tb_d    = tb_q;
    if (step_tick) begin
      if (acc_sum >= TB_MSB[tb_q]) begin
        acc_d   = acc_sum - TB_MSB[tb_q];
        short_d = 1'b1;
      end else begin
        acc_d   = acc_sum;
        short_d = 1'b0;
      end
      // new time base only at the end of a period, no phase jump
      if (short_q) begin
        tb_d = time_base_select;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= '0;
      short_q <= 1'b0;
      tb_q    <= 2'b00;
    end else begin
      acc_q   <= acc_d;
      short_q <= short_d;
      tb_q    <= tb_d;
    end
  end

  assign expire     = counting && step_tick && (cnt_q == CNT_EDGE);
  assign bad_reload = ctrl_wr && (cnt_q > window_q);
  assign halt_fire  = (mode_q == ST_RUN) && pwr.halt_req
                      && !pwr.rtc_irq_enable && halt_reset_option;
  // a write without the top bit is a deliberate software reset
  assign sw_fire     = ctrl_wr && !bus_req.wdata[CNT_TOP_BIT];
  assign reload_fire = bad_reload || sw_fire;
  // ST_HALT_DEC and ST_HALTED may not raise a reset, whatever the counter does
  assign fire        = (active && !rst_block && (expire || reload_fire))
                       || halt_fire;
  assign startup_len = startup_long_sel ? STARTUP_LONG : STARTUP_SHORT;
  assign boot_exit   = boot_q && pwr.halt_exit_rst;

  always_comb begin
    cnt_d = cnt_q;
    if (ctrl_wr) begin
      cnt_d = bus_req.wdata[6:0];
    end else if (counting && step_tick) begin
      cnt_d = cnt_q - 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CTRL_RST_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // only reset clears activation; hence still enabled after leaving halt
  always_comb begin
    act_d = act_bit_q;
    if (ctrl_wr && bus_req.wdata[CTRL_ACT_BIT]) begin
      act_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_bit_q <= CTRL_RST_ACT;
    end else begin
      act_bit_q <= act_d;
    end
  end

  always_comb begin
    window_d = window_q;
    if (win_wr) begin
      window_d = bus_req.wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      window_q <= WINDOW_RST;
    end else begin
      window_q <= window_d;
    end
  end

  always_comb begin
    rd_data_d = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        CTRL_ADDR:   rd_data_d = {act_bit_q, cnt_q};
        WINDOW_ADDR: rd_data_d = {1'b0, window_q};
        default:     rd_data_d = '0;
      endcase
    end
  end

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // reset pulse runs its full length even if retriggered
  always_comb begin
    pulse_d     = pulse_q;
    mcu_rst_n_d = 1'b1;
    if (fire && (pulse_q == '0)) begin
      pulse_d     = 10'(RST_PULSE_CYC - 1);
      mcu_rst_n_d = 1'b0;
    end else if (pulse_q != '0) begin
      pulse_d     = pulse_q - 10'h001;
      mcu_rst_n_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q     <= '0;
      mcu_rst_n_q <= 1'b1;
    end else begin
      pulse_q     <= pulse_d;
      mcu_rst_n_q <= mcu_rst_n_d;
    end
  end

  // strap caught one edge after release, never by the async reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  always_comb begin
    mode_d  = mode_q;
    delay_d = delay_q;
    case (mode_q)
      ST_RUN: begin
        if (boot_exit) begin
          mode_d  = ST_STARTUP;
          delay_d = startup_len;
        end else if (pwr.halt_req && pwr.rtc_irq_enable) begin
          mode_d = ST_ACT_HALT;
        end else if (pwr.halt_req && !halt_reset_option) begin
          mode_d = ST_HALT_DEC;
        end
      end
      ST_HALT_DEC: begin
        if (step_tick) begin
          mode_d = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (pwr.wake_irq) begin
          mode_d  = ST_STARTUP;
          delay_d = startup_len;
        end
      end
      ST_ACT_HALT: begin
        if (pwr.wake_irq) begin
          mode_d = ST_RUN;
        end
      end
      ST_STARTUP: begin
        if (delay_q <= 13'h0001) begin
          mode_d  = ST_RUN;
          delay_d = '0;
        end else begin
          delay_d = delay_q - 13'h0001;
        end
      end
      default: begin
        mode_d  = ST_RUN;
        delay_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= ST_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // cpu clock taken as ref_clk for the start-up delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_q <= '0;
    end else begin
      delay_q <= delay_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_active <= 1'b0;
    end else begin
      wd_active <= active;
    end
  end

  assign rd_data   = rd_data_q;
  assign mcu_rst_n = mcu_rst_n_q;

endmodule : wwdt_top

/* wwdt_top_chk.sv */
// Purpose: port checks for wwdt_top
// Assumes: option inputs change only under reset
// Notes:   halt states are hidden, so the top-clear and halt reset checks stop after a halt
`timescale 1ns/10ps
module wwdt_top_chk
  import wwdt_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire wwdt_bus_req_s bus_req,
  input wire logic [7:0]    rd_data,
  input wire wwdt_pwr_s     pwr,
  input wire logic [1:0]    time_base_select,
  input wire logic          hw_always_on,
  input wire logic          halt_reset_option,
  input wire logic          startup_long_sel,
  input wire logic          mcu_rst_n,
  input wire logic          wd_active
);
  logic [9:0] low_q;
  logic       halt_q;
  logic       run;
  assign run = mcu_rst_n && !halt_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) low_q <= '0;
    else low_q <= mcu_rst_n ? 10'h000 : low_q + 10'h001;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) halt_q <= 1'b0;
    else if (pwr.halt_req) halt_q <= 1'b1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet; mcu_rst_n [*8]; endsequence
  property p_rd_idle; !$past(bus_req.rd) |-> rd_data == 8'h00; endproperty
  property p_win_b7; bus_req.rd && bus_req.addr == WINDOW_ADDR |=> !rd_data[7]; endproperty
  property p_sticky; wd_active |=> wd_active; endproperty
  property p_hw_on; hw_always_on |=> wd_active; endproperty
  property p_top_clr;
    run && wd_active && bus_req.wr && bus_req.addr == CTRL_ADDR && !bus_req.wdata[CNT_TOP_BIT]
    |=> !mcu_rst_n;
  endproperty
  property p_len; $rose(mcu_rst_n) |-> low_q == RST_PULSE_CYC; endproperty
  property p_len_max; !mcu_rst_n |-> low_q < RST_PULSE_CYC; endproperty
  property p_halt_rst;
    run && pwr.halt_req && !pwr.rtc_irq_enable && halt_reset_option |=> !mcu_rst_n;
  endproperty
  property p_halt_q;
    mcu_rst_n && pwr.halt_req && !pwr.rtc_irq_enable && !halt_reset_option |=> s_quiet;
  endproperty
  property p_ahalt_q; mcu_rst_n && pwr.halt_req && pwr.rtc_irq_enable |=> s_quiet; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_win_b7: assert property (p_win_b7) else $error("window bit7 set");
  a_sticky: assert property (p_sticky) else $error("activation lost");
  a_hw_on: assert property (p_hw_on) else $error("hw option inactive");
  a_top_clr: assert property (p_top_clr) else $error("no reset on top bit clear");
  a_len: assert property (p_len) else $error("reset pulse length");
  a_len_max: assert property (p_len_max) else $error("reset pulse too long");
  a_halt_rst: assert property (p_halt_rst) else $error("no reset on halt");
  a_halt_q: assert property (p_halt_q) else $error("reset in plain halt");
  a_ahalt_q: assert property (p_ahalt_q) else $error("reset in active halt");
endmodule : wwdt_top_chk

bind wwdt_top wwdt_top_chk i_wwdt_top_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .pwr(pwr),
  .time_base_select(time_base_select), .hw_always_on(hw_always_on),
  .halt_reset_option(halt_reset_option), .startup_long_sel(startup_long_sel),
  .mcu_rst_n(mcu_rst_n), .wd_active(wd_active)
);

/* test_windowed_watchdog_timer.sv */
// Purpose: directed register tests for wwdt_top
// Assumes: time base 00, short start-up delay
// Notes:   step timing only checked in coarse windows, prescaler phase unknown
`timescale 1ns/10ps
module test_windowed_watchdog_timer;
  import wwdt_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst_n   = 1'b0;
  wwdt_bus_req_s req     = '0;
  wwdt_pwr_s     pwr     = '0;
  logic          hw_on   = 1'b0;
  logic          h_opt   = 1'b0;
  logic [7:0]    rd_data;
  logic          mcu_rst_n;
  logic          wd_active;
  int            n;
  int            err_count = 0;
  int            check_count = 0;
  always #25 ref_clk = ~ref_clk;
  wwdt_top i_wwdt_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req), .rd_data(rd_data), .pwr(pwr),
    .time_base_select(2'b00), .hw_always_on(hw_on), .halt_reset_option(h_opt),
    .startup_long_sel(1'b0), .mcu_rst_n(mcu_rst_n), .wd_active(wd_active)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
    #1;
  endtask : acc
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask : rd_chk
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (mcu_rst_n !== lvl && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_rst
  task automatic restart(input logic hw, input logic opt);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    hw_on <= hw;
    h_opt <= opt;
    pwr <= '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : restart
  task automatic halt(input logic rtc);
    @(posedge ref_clk);
    pwr <= '{halt_req: 1'b1, wake_irq: 1'b0, rtc_irq_enable: rtc, halt_exit_rst: 1'b0};
    @(posedge ref_clk);
    pwr.halt_req <= 1'b0;
    #1;
  endtask : halt
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    #5_000_000;
    err_count++;
    test_done();
  end
  initial begin
    restart(1'b0, 1'b0);
    chk({15'h0, wd_active}, 16'h0000);
    rd_chk(CTRL_ADDR, 8'h7F);
    rd_chk(WINDOW_ADDR, 8'h7F);
    rd_chk(8'h31, 8'h00);
    acc(1'b1, WINDOW_ADDR, 8'hFF);
    rd_chk(WINDOW_ADDR, 8'h7F);
    acc(1'b1, CTRL_ADDR, 8'h7F);
    repeat (16500) @(posedge ref_clk);
    rd_chk(CTRL_ADDR, 8'h7E);
    acc(1'b1, CTRL_ADDR, 8'hC5);
    rd_chk(CTRL_ADDR, 8'hC5);
    acc(1'b1, CTRL_ADDR, 8'h05);
    chk({15'h0, wd_active}, 16'h0001);
    wait_rst(1'b1, 700);
    chk(n[15:0], 16'h0258);
    // a reload inside the window is safe, above it is not
    restart(1'b0, 1'b0);
    acc(1'b1, CTRL_ADDR, 8'hC5);
    acc(1'b1, CTRL_ADDR, 8'hC5);
    chk({15'h0, mcu_rst_n}, 16'h0001);
    acc(1'b1, WINDOW_ADDR, 8'h40);
    acc(1'b1, CTRL_ADDR, 8'hC5);
    chk({15'h0, mcu_rst_n}, 16'h0000);
    restart(1'b0, 1'b0);
    acc(1'b1, CTRL_ADDR, 8'hC0);
    wait_rst(1'b0, 17000);
    chk({15'h0, n > 11000 && n < 16400}, 16'h0001);
    restart(1'b0, 1'b1);
    halt(1'b0);
    chk({15'h0, mcu_rst_n}, 16'h0000);
    restart(1'b0, 1'b0);
    acc(1'b1, CTRL_ADDR, 8'hC0);
    halt(1'b0);
    repeat (16500) @(posedge ref_clk);
    rd_chk(CTRL_ADDR, 8'hBF);
    chk({15'h0, mcu_rst_n}, 16'h0001);
    restart(1'b0, 1'b0);
    acc(1'b1, CTRL_ADDR, 8'hC2);
    halt(1'b1);
    repeat (16500) @(posedge ref_clk);
    rd_chk(CTRL_ADDR, 8'hC2);
    @(posedge ref_clk);
    pwr.wake_irq <= 1'b1;
    @(posedge ref_clk);
    pwr.wake_irq <= 1'b0;
    repeat (16100) @(posedge ref_clk);
    rd_chk(CTRL_ADDR, 8'hC1);
    restart(1'b1, 1'b0);
    acc(1'b1, CTRL_ADDR, 8'h45);
    chk({15'h0, wd_active}, 16'h0001);
    acc(1'b1, CTRL_ADDR, 8'h05);
    chk({15'h0, mcu_rst_n}, 16'h0000);
    test_done();
  end
endmodule : test_windowed_watchdog_timer
